// ### verilog/strap_pkg.sv
// Strap decode and management pin mux constants and types
package strap_pkg;
   localparam int          STRAP_W          = 16;
   localparam int          FAST_PORTS       = 8;
   localparam int          FILTER_BIT       = 0;
   localparam int          MODE_LSB         = 1;
   localparam int          MODE_W           = 3;
   localparam int          DEV_ID_LSB       = 4;
   localparam int          DEV_ID_W         = 3;
   localparam int          EEPROM_BIT       = 7;
   localparam int          HOTSWAP_BIT      = 9;
   localparam int          PWR_SAVE_BIT     = 11;
   localparam int          TIMEOUT_BIT      = 12;
   localparam int          GIG_HALF_BIT     = 13;
   localparam logic [2:0]  MODE_PAR16       = 3'h0;
   localparam logic [2:0]  MODE_PAR8        = 3'h1;
   localparam logic [2:0]  MODE_SER_MII     = 3'h2;
   localparam logic [2:0]  MODE_SER_ONLY    = 3'h3;
   localparam logic [2:0]  MODE_SER_I2C     = 3'h7;
   localparam int          CLK_MHZ          = 250;
   // Timeout limit in seconds, and in cycles at the clock rate
   localparam longint      TIMEOUT_S        = 5;
   localparam longint      TIMEOUT_CYC      = TIMEOUT_S * CLK_MHZ * 1000000;
   // Idle span before a port MAC enters power saving, in microseconds
   localparam longint      IDLE_US          = 100;
   localparam longint      IDLE_CYC         = IDLE_US * CLK_MHZ;
   localparam int          CNT_W            = 33;

   typedef enum logic [4:0] {
      HOST_PAR16    = 5'h01,
      HOST_PAR8     = 5'h02,
      HOST_SER_MII  = 5'h04,
      HOST_SER_ONLY = 5'h08,
      HOST_SER_I2C  = 5'h10
   } host_mode_t;
endpackage

// ### verilog/strap_decode_mgmt_pin_mux.sv
// Strap capture, host mode decode, management pin mux and monitors
// ---------------------------------------------------------------
// Overview of operation
// - Capture all straps at the first clock edge after reset release.
// - Strap bits 3:1 select host interface.
// - Address pins become I2C only in 111.
// - Bit 0 switches serial input filter.
// - Serial modes take identifier from bits 6:4.
// - Bit 7 enables EEPROM load after reset.
// - Bit 9 enables module hotswap.
// - Hotswap module type from transmit-enable and uplink transmit-error straps.
// - Bit 11: idle ports enter power saving.
// - Activity returns port to normal operation.
// - Bit 12 enables five-second stuck monitor.
// - Serial carries registers, MII carries packets.
// - Unmanaged mode rejects all host control frames.
// - Stuck machine triggers reset or interrupt.
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module strap_decode_mgmt_pin_mux
   import strap_pkg::*;
#(
   parameter longint TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter longint IDLE_CYCLES    = IDLE_CYC
) (
   input  wire  logic                  mclk,
   input  wire  logic                  rst,
   input  wire  logic [STRAP_W-1:0]    strap_pins,
   input  wire  logic [FAST_PORTS-1:0] fast_port_tx_enable,
   input  wire  logic                  uplink_tx_enable,
   input  wire  logic                  uplink_tx_error,
   input  wire  logic [FAST_PORTS:0]   port_activity,
   input  wire  logic                  sm_busy,
   input  wire  logic                  timeout_action_reset,
   input  wire  logic                  host_ctrl_frame,
   input  wire  logic                  core_irq,
   input  wire  logic                  core_serial_out,
   input  wire  logic                  i2c_sda_drive_low,
   input  wire  logic                  i2c_scl_drive,
   input  wire  logic [3:0]            cpu_frame_txd,
   input  wire  logic                  cpu_frame_tx_clk,
   input  wire  logic                  cpu_frame_tx_valid,
   input  wire  logic                  cpu_frame_rx_clk,
   input  wire  logic                  pin_we_n,
   input  wire  logic                  pin_rd_n,
   input  wire  logic                  pin_cs_n,
   input  wire  logic [2:0]            pin_addr_in,
   input  wire  logic [15:0]           pin_data_in,
   output logic [2:0]                  pin_addr_out,
   output logic [2:0]                  pin_addr_oe_n,
   output logic                        pin_rd_out,
   output logic                        pin_rd_oe_n,
   output logic                        pin_int_n,
   output logic [15:0]                 pin_data_out,
   output logic [15:0]                 pin_data_oe_n,
   output host_mode_t                  host_mode,
   output logic                        parallel_sel,
   output logic                        parallel_wide,
   output logic                        serial_sel,
   output logic                        serial_strobe,
   output logic                        serial_in_line,
   output logic                        serial_input_filter,
   output logic                        i2c_sda_in,
   output logic [2:0]                  device_id,
   output logic                        eeprom_load_start,
   output logic                        hotswap_enable,
   output logic [FAST_PORTS-1:0]       fast_port_module,
   output logic [1:0]                  uplink_module,
   output logic                        gig_half_duplex,
   output logic [FAST_PORTS:0]         port_power_save,
   output logic                        frame_path_mii,
   output logic                        ctrl_frame_accept,
   output logic                        ctrl_frame_reject,
   output logic [3:0]                  cpu_frame_rxd,
   output logic                        cpu_frame_rx_valid,
   output logic                        timeout_reset_req,
   output logic                        timeout_irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   // Whole block state, registered in one place
   typedef struct packed {
      logic [STRAP_W-1:0]    straps;
      logic [FAST_PORTS-1:0] fast_mod;
      logic [1:0]            up_mod;
      logic                  captured;
      logic                  eeprom_go;
      logic [FAST_PORTS:0]   psave;
      logic [FAST_PORTS:0][CNT_W-1:0] idle;
      logic [CNT_W-1:0]      sm_cnt;
      logic                  to_rst;
      logic                  to_irq;
      logic                  rej;
      logic [4:0]            rxd;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [2:0]       mode_code;
   logic             to_hit;

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   function automatic host_mode_t decode_mode(input logic [2:0] code);
      case (code)
         MODE_PAR16:    decode_mode = HOST_PAR16;
         MODE_PAR8:     decode_mode = HOST_PAR8;
         MODE_SER_MII:  decode_mode = HOST_SER_MII;
         MODE_SER_ONLY: decode_mode = HOST_SER_ONLY;
         MODE_SER_I2C:  decode_mode = HOST_SER_I2C;
         // Unlisted codes fall back to the plain serial-only mode
         default:       decode_mode = HOST_SER_ONLY;
      endcase
   endfunction

   // Counters saturate at their limit, so reaching it is a compare
   function automatic logic limit_hit(input logic [CNT_W-1:0] cnt,
                                      input longint           limit);
      limit_hit = (cnt >= CNT_W'(limit));
   endfunction

   assign mode_code = s_q.straps[MODE_LSB +: MODE_W];
   // Shared by both flag outputs so they can never disagree
   assign to_hit    = limit_hit(s_q.sm_cnt, TIMEOUT_CYCLES);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.eeprom_go = 1'b0;
      // Straps follow the pins until the first edge after release
      if (!s_q.captured) begin
         s_d.straps   = strap_pins;
         s_d.fast_mod = fast_port_tx_enable;
         s_d.up_mod   = {uplink_tx_error, uplink_tx_enable};
         s_d.captured = 1'b1;
         s_d.eeprom_go = strap_pins[EEPROM_BIT];
      end

      // Timeout monitor; the counter saturates at the limit
      if (!s_q.straps[TIMEOUT_BIT] || !sm_busy) begin
         s_d.sm_cnt = '0;
      end else if (!to_hit) begin
         s_d.sm_cnt = s_q.sm_cnt + CNT_W'(1);
      end
      // Flags follow the count a cycle late and drop once busy ends
      s_d.to_rst = to_hit && timeout_action_reset;
      s_d.to_irq = to_hit && !timeout_action_reset;

      // Only the lightly managed and managed modes take control frames
      s_d.rej = host_ctrl_frame && (host_mode == HOST_SER_I2C);
      s_d.rxd = {pin_data_in[13], pin_data_in[11:8]};

      // Idle counters saturate so a quiet port never wraps back awake
      for (int p = 0; p <= FAST_PORTS; p++) begin
         if (!s_q.straps[PWR_SAVE_BIT] || port_activity[p]) begin
            s_d.idle[p]  = '0;
            s_d.psave[p] = 1'b0;
         end else begin
            if (!limit_hit(s_q.idle[p], IDLE_CYCLES)) begin
               s_d.idle[p] = s_q.idle[p] + CNT_W'(1);
            end
            if (limit_hit(s_q.idle[p], IDLE_CYCLES)) begin
               s_d.psave[p] = 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Asynchronous clear; straps are taken again after every reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Decoded configuration
   // ------------------------------------------------------------
   // Decode reads the captured copy, never the live pins
   assign host_mode     = decode_mode(mode_code);
   always_comb begin
      parallel_sel  = 1'b0;
      parallel_wide = 1'b0;
      case (host_mode)
         HOST_PAR16: begin
            parallel_sel  = 1'b1;
            parallel_wide = 1'b1;
         end
         HOST_PAR8: begin
            parallel_sel  = 1'b1;
         end
         default: begin
            parallel_sel  = 1'b0;
         end
      endcase
   end
   assign serial_sel    = !parallel_sel;

   // Serial-only options read as zero in parallel modes
   assign serial_input_filter = serial_sel && s_q.straps[FILTER_BIT];
   assign device_id     = serial_sel ?
                          s_q.straps[DEV_ID_LSB +: DEV_ID_W] : 3'h0;
   assign eeprom_load_start = s_q.eeprom_go;
   assign hotswap_enable    = s_q.straps[HOTSWAP_BIT];
   assign fast_port_module  = hotswap_enable ? s_q.fast_mod : '0;
   assign uplink_module     = hotswap_enable ? s_q.up_mod : 2'h0;
   // Left to the board to set only with a half-duplex capable PHY
   assign gig_half_duplex   = s_q.straps[GIG_HALF_BIT];
   assign port_power_save   = s_q.psave;

   // Frame routing and the control frame gate
   assign frame_path_mii    = (host_mode == HOST_SER_MII);
   assign ctrl_frame_accept = host_ctrl_frame
                              && (host_mode != HOST_SER_I2C);
   assign ctrl_frame_reject = s_q.rej;

   // Monitor flags
   assign timeout_reset_req = s_q.to_rst;
   assign timeout_irq       = s_q.to_irq;

   // ------------------------------------------------------------
   // Pin mux
   // ------------------------------------------------------------
   // Interrupt pin keeps its role in every mode
   assign pin_int_n = !core_irq;

   // Serial remap shared by all three serial modes
   always_comb begin
      serial_strobe  = 1'b0;
      serial_in_line = 1'b0;
      pin_rd_out     = 1'b0;
      pin_rd_oe_n    = 1'b1;
      case (host_mode)
         HOST_SER_MII, HOST_SER_ONLY, HOST_SER_I2C: begin
            serial_strobe  = !pin_we_n;
            serial_in_line = pin_cs_n;
            pin_rd_out     = core_serial_out;
            pin_rd_oe_n    = 1'b0;
         end
         default: begin
            // Parallel modes leave the read pin to the bus engine
            pin_rd_oe_n    = 1'b1;
         end
      endcase
   end

   // Address pins: open drain data, pushed clock, unmanaged mode only
   always_comb begin
      pin_addr_out  = 3'h0;
      pin_addr_oe_n = 3'h7;
      i2c_sda_in    = 1'b1;
      case (host_mode)
         HOST_SER_I2C: begin
            pin_addr_oe_n[0] = !i2c_sda_drive_low;
            pin_addr_out[1]  = i2c_scl_drive;
            pin_addr_oe_n[1] = 1'b0;
            i2c_sda_in       = pin_addr_in[0];
         end
         default: begin
            // Released data line reads as its pull-up
            i2c_sda_in       = 1'b1;
         end
      endcase
   end

   // Frame pins only in the serial-with-MII mode
   always_comb begin
      pin_data_out  = 16'h0000;
      pin_data_oe_n = 16'hFFFF;
      case (host_mode)
         HOST_SER_MII: begin
            pin_data_out[3:0]  = cpu_frame_txd;
            pin_data_out[4]    = cpu_frame_tx_clk;
            pin_data_out[5]    = cpu_frame_tx_valid;
            pin_data_out[12]   = cpu_frame_rx_clk;
            pin_data_oe_n[5:0] = 6'h00;
            pin_data_oe_n[12]  = 1'b0;
         end
         default: begin
            // Other modes never drive the data pins from here
            pin_data_oe_n      = 16'hFFFF;
         end
      endcase
   end

   assign cpu_frame_rxd      = frame_path_mii ? s_q.rxd[3:0] : 4'h0;
   assign cpu_frame_rx_valid = frame_path_mii ? s_q.rxd[4] : 1'b0;

endmodule
`default_nettype wire

// ### testbench/strap_mux_asserts.sv
// Port-level checker for strap decode and management pin mux
`timescale 1ns/10ps
`default_nettype none
module strap_mux_asserts
   import strap_pkg::*;
#(
   parameter longint TIMEOUT_CYCLES = 20
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire host_mode_t  host_mode,
   input wire logic        core_irq,
   input wire logic        pin_int_n,
   input wire logic        pin_we_n,
   input wire logic        pin_cs_n,
   input wire logic        serial_sel,
   input wire logic        serial_strobe,
   input wire logic        serial_in_line,
   input wire logic [2:0]  pin_addr_oe_n,
   input wire logic [3:0]  cpu_frame_txd,
   input wire logic [15:0] pin_data_out,
   input wire logic [15:0] pin_data_oe_n,
   input wire logic        host_ctrl_frame,
   input wire logic        ctrl_frame_reject,
   input wire logic        sm_busy,
   input wire logic        timeout_reset_req,
   input wire logic        timeout_irq,
   input wire logic [8:0]  port_activity,
   input wire logic [8:0]  port_power_save,
   input wire logic        eeprom_load_start
);
   logic [31:0] busy_cnt_q;
   // Run length of busy, so a flag can be tied to its cause
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy_cnt_q <= 32'h0;
      end else begin
         busy_cnt_q <= sm_busy ? busy_cnt_q + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_one_pulse;
      eeprom_load_start ##1 !eeprom_load_start;
   endsequence
   property p_int_pin; pin_int_n == !core_irq; endproperty
   property p_remap;
      serial_sel |-> serial_strobe == !pin_we_n && serial_in_line == pin_cs_n;
   endproperty
   property p_addr_idle;
      host_mode != HOST_SER_I2C |-> pin_addr_oe_n[1:0] == 2'h3;
   endproperty
   property p_mii_tx;
      host_mode == HOST_SER_MII |->
         pin_data_out[3:0] == cpu_frame_txd && pin_data_oe_n[5:0] == 6'h00;
   endproperty
   property p_reject;
      host_ctrl_frame && host_mode == HOST_SER_I2C |=> ctrl_frame_reject;
   endproperty
   property p_timeout;
      timeout_reset_req || timeout_irq |-> $past(busy_cnt_q) >= TIMEOUT_CYCLES;
   endproperty
   property p_wake;
      |(port_activity & port_power_save) |=>
         (port_power_save & $past(port_activity)) == 9'h000;
   endproperty
   property p_eeprom;
      $rose(eeprom_load_start) |-> $past(rst, 2) ##0 s_one_pulse;
   endproperty
   property p_hold;
      !$past(rst) && !$past(rst, 2) |-> $stable(host_mode);
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("int pin wrong");
   a_remap: assert property (p_remap) else $error("serial remap wrong");
   a_addr_idle: assert property (p_addr_idle) else $error("addr driven");
   a_mii_tx: assert property (p_mii_tx) else $error("mii tx pins wrong");
   a_reject: assert property (p_reject) else $error("frame not rejected");
   a_timeout: assert property (p_timeout) else $error("early timeout");
   a_wake: assert property (p_wake) else $error("port stays asleep");
   a_eeprom: assert property (p_eeprom) else $error("bad eeprom pulse");
   a_hold: assert property (p_hold) else $error("mode changed");
endmodule
`default_nettype wire

// ### testbench/host_pin_model.sv
// Host side model driving the shared management pins
`timescale 1ns/10ps
`default_nettype none
module host_pin_model (
   input  wire logic   mclk,
   output logic        pin_we_n,
   output logic        pin_cs_n,
   output logic [2:0]  pin_addr_in,
   output logic [15:0] pin_data_in
);
   logic [31:0] pat_q = 32'h1;
   // New levels every cycle so a stale copy never matches by luck
   always @(posedge mclk) begin
      pat_q <= #1 pat_q * 32'h0019660D + 32'h3C6EF35F;
   end
   assign {pin_we_n, pin_cs_n, pin_addr_in, pin_data_in} = pat_q[20:0];
endmodule
`default_nettype wire

// ### testbench/strap_decode_mgmt_pin_mux_tb.sv
// Self-checking bench for strap decode and management pin mux
`timescale 1ns/10ps
`default_nettype none
module strap_decode_mgmt_pin_mux_tb;
   import strap_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, sm_busy = 1'b0, host_ctrl_frame = 1'b0;
   logic [15:0] strap_pins = 16'h0, s_cap, d;
   logic [7:0] fast_port_tx_enable = 8'h0;
   logic uplink_tx_enable = 1'b0, uplink_tx_error = 1'b0;
   logic timeout_action_reset = 1'b0;
   logic [8:0] port_activity = 9'h1FF;
   logic [9:0] mods;
   logic [31:0] rv = 32'h0;
   wire logic core_irq, core_serial_out, i2c_sda_drive_low, i2c_scl_drive;
   wire logic cpu_frame_tx_clk, cpu_frame_tx_valid, cpu_frame_rx_clk;
   wire logic [3:0] cpu_frame_txd;
   wire logic pin_we_n, pin_cs_n;
   wire logic [2:0] pin_addr_in;
   wire logic [15:0] pin_data_in;
   host_mode_t host_mode;
   logic [2:0] device_id;
   logic serial_input_filter, eeprom_load_start, hotswap_enable;
   logic gig_half_duplex, ctrl_frame_accept, ctrl_frame_reject;
   logic cpu_frame_rx_valid, timeout_reset_req, timeout_irq;
   logic [7:0] fast_port_module;
   logic [1:0] uplink_module;
   logic [8:0] port_power_save;
   logic [3:0] cpu_frame_rxd;
   logic [2:0] pin_addr_out, pin_addr_oe_n;
   logic [15:0] pin_data_oe_n;
   logic pin_rd_out, pin_rd_oe_n, parallel_sel, parallel_wide;
   logic frame_path_mii, i2c_sda_in;
   int seed = 37, num_errors = 0, tests_run = 0;
   always #2 mclk = ~mclk;
   always @(posedge mclk) rv <= #1 $random(seed);
   assign {core_irq, core_serial_out, i2c_sda_drive_low, i2c_scl_drive,
      cpu_frame_txd, cpu_frame_tx_clk, cpu_frame_tx_valid,
      cpu_frame_rx_clk} = rv[10:0];
   host_pin_model u_host (.mclk, .pin_we_n, .pin_cs_n, .pin_addr_in,
      .pin_data_in);
   strap_decode_mgmt_pin_mux #(.TIMEOUT_CYCLES(20), .IDLE_CYCLES(10)) DUT (
      .mclk, .rst, .strap_pins, .fast_port_tx_enable, .uplink_tx_enable,
      .uplink_tx_error, .port_activity, .sm_busy, .timeout_action_reset,
      .host_ctrl_frame, .core_irq, .core_serial_out, .i2c_sda_drive_low,
      .i2c_scl_drive, .cpu_frame_txd, .cpu_frame_tx_clk, .cpu_frame_tx_valid,
      .cpu_frame_rx_clk, .pin_we_n, .pin_rd_n(1'b1), .pin_cs_n, .pin_addr_in,
      .pin_data_in, .pin_addr_out, .pin_addr_oe_n, .pin_rd_out,
      .pin_rd_oe_n, .pin_int_n(), .pin_data_out(), .pin_data_oe_n,
      .host_mode, .parallel_sel, .parallel_wide, .serial_sel(),
      .serial_strobe(), .serial_in_line(), .serial_input_filter,
      .i2c_sda_in, .device_id, .eeprom_load_start, .hotswap_enable,
      .fast_port_module, .uplink_module, .gig_half_duplex, .port_power_save,
      .frame_path_mii, .ctrl_frame_accept, .ctrl_frame_reject,
      .cpu_frame_rxd, .cpu_frame_rx_valid, .timeout_reset_req, .timeout_irq);
   function automatic host_mode_t exp_mode(input logic [2:0] c);
      case (c)
         3'h0: return HOST_PAR16;
         3'h1: return HOST_PAR8;
         3'h2: return HOST_SER_MII;
         3'h7: return HOST_SER_I2C;
         default: return HOST_SER_ONLY;
      endcase
   endfunction
   task automatic chk(input string n, input logic [15:0] s, e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic final_report();
      if (num_errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      num_errors++;
      final_report();
   end
   initial begin
      for (int m = 0; m < 8; m++) begin
         s_cap = 16'($random(seed));
         s_cap[3:1] = m[2:0];
         strap_pins = s_cap;
         mods = 10'($random(seed));
         {uplink_tx_error, uplink_tx_enable, fast_port_tx_enable} = mods;
         rst = 1'b1;
         step(20);
         rst = 1'b0;
         step(1);
         chk("mode", 16'(host_mode), 16'(exp_mode(m[2:0])));
         chk("eeprom", 16'(eeprom_load_start), 16'(s_cap[7]));
         chk("id", 16'(device_id), m > 1 ? 16'(s_cap[6:4]) : 16'h0);
         chk("filter", 16'(serial_input_filter),
            m > 1 ? 16'(s_cap[0]) : 16'h0);
         chk("hotswap", 16'(hotswap_enable), 16'(s_cap[9]));
         chk("half", 16'(gig_half_duplex), 16'(s_cap[GIG_HALF_BIT]));
         strap_pins = ~s_cap;
         fast_port_tx_enable = ~fast_port_tx_enable;
         step(1);
         chk("held", 16'(host_mode), 16'(exp_mode(m[2:0])));
         chk("modules", 16'({uplink_module, fast_port_module}),
            s_cap[9] ? 16'(mods) : 16'h0);
         chk("eeprom end", 16'(eeprom_load_start), 16'h0);
         host_ctrl_frame = 1'b1;
         #1 chk("accept", 16'(ctrl_frame_accept), 16'(m != 7));
         chk("i2c", 16'({i2c_sda_in, pin_addr_oe_n, pin_addr_out[1]}),
            m == 7 ? 16'({pin_addr_in[0], 2'h2, !i2c_sda_drive_low,
            i2c_scl_drive}) : 16'h1E);
         chk("rd", 16'({pin_rd_oe_n, pin_rd_out}),
            m > 1 ? 16'({1'b0, core_serial_out}) : 16'h2);
         chk("sel", 16'({parallel_sel, parallel_wide, frame_path_mii}),
            16'({m < 2, m == 0, m == 2}));
         chk("data oe", pin_data_oe_n, m == 2 ? 16'hEFC0 : 16'hFFFF);
         @(posedge mclk) d = pin_data_in;
         #1 host_ctrl_frame = 1'b0;
         chk("reject", 16'(ctrl_frame_reject), 16'(m == 7));
         chk("rx", 16'({cpu_frame_rx_valid, cpu_frame_rxd}),
            m == 2 ? 16'({d[13], d[11:8]}) : 16'h0);
         timeout_action_reset = 1'($random(seed));
         sm_busy = 1'b1;
         port_activity = 9'h000;
         step(12);
         chk("early", 16'({timeout_reset_req, timeout_irq}), 16'h0);
         step(18);
         chk("flags", 16'({timeout_reset_req, timeout_irq}),
            16'({s_cap[12] & timeout_action_reset,
            s_cap[12] & !timeout_action_reset}));
         chk("psave", 16'(port_power_save), s_cap[11] ? 16'h01FF : 16'h0);
         sm_busy = 1'b0;
         port_activity = 9'h001;
         step(2);
         chk("clear", 16'({timeout_reset_req, timeout_irq}), 16'h0);
         chk("wake", 16'(port_power_save), s_cap[11] ? 16'h01FE : 16'h0);
         port_activity = 9'h1FF;
      end
      final_report();
   end
endmodule
bind strap_decode_mgmt_pin_mux strap_mux_asserts #(
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_chk (.mclk, .rst, .host_mode, .core_irq, .pin_int_n, .pin_we_n,
   .pin_cs_n, .serial_sel, .serial_strobe, .serial_in_line, .pin_addr_oe_n,
   .cpu_frame_txd, .pin_data_out, .pin_data_oe_n, .host_ctrl_frame,
   .ctrl_frame_reject, .sm_busy, .timeout_reset_req, .timeout_irq,
   .port_activity, .port_power_save, .eeprom_load_start);
`default_nettype wire
